// ---- adc_model.sv ----
`timescale 1ns/1ps
module adc_model
    import touch_regs_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       conv_start_q,
    input  wire logic [2:0] conv_channel_q,
    input  wire logic [3:0] lat,
    output adc_result_t     adc_result,
    output int              n_conv
);
    logic [15:0] level [0:6] = '{16'h0111, 16'h0222, 16'h0333, 16'h0444, 16'h0aaa, 16'h0100,
                                 16'h0600};
    logic [2:0]  ch;
    int          cnt = 0;

    initial adc_result = '0;
    initial n_conv = 0;

    // data line toggles outside the result pulse
    always @(posedge core_clk)
    begin
        adc_result.valid <= 1'b0;
        adc_result.data  <= ~adc_result.data;
        if (conv_start_q)
        begin
            ch     <= conv_channel_q;
            cnt    <= lat;
            n_conv <= n_conv + 1;
        end
        else if (cnt == 1)
        begin
            adc_result <= '{valid: 1'b1, data: level[ch]};
            cnt        <= 0;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
    end
endmodule : adc_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import touch_regs_pkg::*;
;
    logic        core_clk = 0, rst_n = 0, seq_start = 0, gpio_enable = 0;
    logic        pen_irq_enable = 1, touch_pin = 0, gpio_event_pin = 0;
    logic [3:0]  first_conversion_delay = 4'h3, lat = 4'h3;
    reg_req_t    reg_req = '0;
    logic [15:0] rd_data_q;
    logic        rd_valid_q, conv_start_q, seq_busy_q, touch_detect_output_n_q;
    logic [2:0]  conv_channel_q;
    adc_result_t adc_result;
    int          n_conv, miscompares = 0, n_checks = 0, cycles = 0;

    touch_adc_sequence_alert_regs #(.FCD_STEP_CYC(2)) dut (.core_clk, .rst_n, .reg_req,
        .rd_data_q, .rd_valid_q, .seq_start, .first_conversion_delay, .gpio_enable,
        .pen_irq_enable, .touch_pin, .gpio_event_pin, .conv_start_q, .conv_channel_q,
        .adc_result, .seq_busy_q, .touch_detect_output_n_q);
    adc_model adc (.core_clk, .conv_start_q, .conv_channel_q, .lat, .adc_result, .n_conv);

    initial forever #20 core_clk = ~core_clk;

    always @(posedge core_clk)
        if (++cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        step();
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        step();
        reg_req = '0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        step();
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        step();
        reg_req = '0;
        chk({15'h0, rd_valid_q}, 16'h0001);
        chk(rd_data_q, exp);
    endtask : rdc

    task automatic out_is(input logic v);
        chk({15'h0, touch_detect_output_n_q}, {15'h0, v});
    endtask : out_is

    task automatic run_seq();
        int n;
        step();
        seq_start = 1'b1;
        step();
        seq_start = 1'b0;
        n = 0;
        while (seq_busy_q !== 1'b0 && n < 2000)
        begin
            step();
            n++;
        end
        chk({15'h0, seq_busy_q}, 16'h0000);
    endtask : run_seq

    task automatic t_reset_vals();
        rdc(SEQ_CTRL_ADDR, 16'h1000);
        for (int a = 4; a < 14; a++)
            rdc(8'(a), 16'h0000);
        rdc(IDENTITY_ADDR, IDENTITY_WORD);
    endtask : t_reset_vals

    task automatic t_access();
        wr(SEQ_CTRL_ADDR, 16'hffff);
        rdc(SEQ_CTRL_ADDR, 16'hf0fe);
        wr(8'h0c, 16'h1234);
        rdc(8'h0c, 16'h0000);
        wr(8'h20, 16'h5678);
        rdc(8'h20, 16'h0000);
    endtask : t_access

    task automatic t_seq();
        logic [15:0] res [0:5] = '{16'h0111, 16'h0222, 16'h0333, 16'h0444, 16'h0100, 16'h0600};
        wr(SIDE_HIGH_ADDR, 16'h0800);
        wr(SIDE_LOW_ADDR, 16'h0200);
        wr(THERM_HIGH_ADDR, 16'h0500);
        wr(THERM_LOW_ADDR, 16'h0100);
        rdc(SIDE_LOW_ADDR, 16'h0200);
        rdc(THERM_HIGH_ADDR, 16'h0500);
        wr(SEQ_CTRL_ADDR, 16'h30fe);
        run_seq();
        for (int i = 0; i < 6; i++)
            rdc(RESULT_FIRST_ADDR + 8'(i), res[i]);
        rdc(SEQ_CTRL_ADDR, 16'h39fe);
        out_is(1'b0);
        wr(SEQ_CTRL_ADDR, 16'h70fe);
        step();
        out_is(1'b0);
        wr(SEQ_CTRL_ADDR, 16'hb0fe);
        step();
        out_is(1'b0);
        wr(SEQ_CTRL_ADDR, 16'hf0fe);
        step();
        out_is(1'b1);
    endtask : t_seq

    task automatic t_dav();
        wr(SEQ_CTRL_ADDR, 16'hd002);
        run_seq();
        step();
        out_is(1'b0);
        rdc(8'h0d, 16'h0600);
        step();
        step();
        out_is(1'b1);
    endtask : t_dav

    task automatic t_gpio();
        int n0;
        gpio_enable = 1'b1;
        lat = 4'h8;
        wr(SEQ_CTRL_ADDR, 16'hf00e);
        n0 = n_conv;
        run_seq();
        chk(16'(n_conv - n0), 16'h0001);
        gpio_event_pin = 1'b1;
        repeat (4) step();
        out_is(1'b1);
        gpio_event_pin = 1'b0;
        repeat (2) step();
        wr(SEQ_CTRL_ADDR, 16'he000);
        step();
        out_is(1'b1);
        gpio_event_pin = 1'b1;
        repeat (4) step();
        gpio_event_pin = 1'b0;
        out_is(1'b0);
        gpio_enable = 1'b0;
        wr(SEQ_CTRL_ADDR, 16'hf008);
        run_seq();
        rdc(8'h0c, 16'h0aaa);
    endtask : t_gpio

    task automatic t_pen();
        pen_irq_enable = 1'b0;
        touch_pin = 1'b1;
        repeat (5) step();
        out_is(1'b0);
        touch_pin = 1'b0;
        repeat (5) step();
        out_is(1'b1);
    endtask : t_pen

    initial
    begin
        repeat (8) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        t_reset_vals();
        t_access();
        t_seq();
        t_dav();
        t_gpio();
        t_pen();
        wrap_up();
    end
endmodule : tb_top

bind touch_adc_sequence_alert_regs touch_regs_properties #(.FCD_STEP_CYC(2)) props (.core_clk,
    .rst_n, .reg_req, .rd_data_q, .rd_valid_q, .seq_start, .first_conversion_delay,
    .gpio_enable, .pen_irq_enable, .touch_pin, .gpio_event_pin, .conv_start_q,
    .conv_channel_q, .adc_result, .seq_busy_q, .touch_detect_output_n_q);

// ---- touch_adc_sequence_alert_regs.sv ----
`timescale 1ns/1ps
module touch_adc_sequence_alert_regs
    import touch_regs_pkg::*;
#(
    parameter int FCD_STEP_CYC = FCD_STEP_CYCLES
)(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire reg_req_t    reg_req,
    output logic [15:0]      rd_data_q,
    output logic             rd_valid_q,
    input  wire logic        seq_start,
    input  wire logic [3:0]  first_conversion_delay,
    input  wire logic        gpio_enable,
    input  wire logic        pen_irq_enable,
    input  wire logic        touch_pin,
    input  wire logic        gpio_event_pin,
    output logic             conv_start_q,
    output logic [2:0]       conv_channel_q,
    input  wire adc_result_t adc_result,
    output logic             seq_busy_q,
    output logic             touch_detect_output_n_q
);

    logic [15:0]      ctrl_q;
    logic [15:0]      limits_q [4];
    logic [15:0]      results_q [NUM_RESULTS];
    logic [NUM_CH-1:0] chan_en;
    logic [1:0]       touch_sync_q;
    logic [1:0]       gpio_sync_q;
    logic             gpio_seen_q;
    logic             result_ready_q;
    logic             first_q;
    seq_state_t       state_q;
    logic [2:0]       idx_q;
    logic [19:0]      delay_q;
    logic [3:0]       flags_d;
    logic             alert_req;
    logic             irq_level;
    logic [2:0]       slot;
    logic             ctrl_wr;
    logic             limit_hit;
    logic             result_hit;
    logic             result_take;
    logic             seq_done;
    logic             needs_delay;
    logic [19:0]      delay_load;
    logic [15:0]      rd_data_d;
    logic             side_below;
    logic             side_above;
    logic             therm_below;
    logic             therm_above;

    // pin synchronisers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            touch_sync_q <= 2'h0;
            gpio_sync_q  <= 2'h0;
        end
        else
        begin
            touch_sync_q <= {touch_sync_q[0], touch_pin};
            gpio_sync_q  <= {gpio_sync_q[0], gpio_event_pin};
        end
    end

    // sequence channel enables
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_chan_en
        if (i == CH_AUX)
        begin : g_aux
            assign chan_en[i] = ctrl_q[SEQ_EN_TOP_BIT-i] & ~gpio_enable
                              & ~ctrl_q[SEQ_EN_TOP_BIT-CH_BATT];
        end
        else if (i == CH_BATT)
        begin : g_batt
            assign chan_en[i] = ctrl_q[SEQ_EN_TOP_BIT-i] & ~gpio_enable;
        end
        else
        begin : g_plain
            assign chan_en[i] = ctrl_q[SEQ_EN_TOP_BIT-i];
        end
    end

    // result slot: aux and battery share one register
    always_comb
    begin
        if (conv_channel_q == CH_BATT || conv_channel_q == CH_THERM)
            slot = conv_channel_q - 3'h1;
        else
            slot = conv_channel_q;
    end

    // bus and sequencer decode
    always_comb
    begin
        ctrl_wr     = reg_req.wr && reg_req.addr == SEQ_CTRL_ADDR;
        limit_hit   = reg_req.addr >= SIDE_HIGH_ADDR && reg_req.addr <= THERM_LOW_ADDR;
        result_hit  = reg_req.addr >= RESULT_FIRST_ADDR && reg_req.addr <= RESULT_LAST_ADDR;
        result_take = state_q == SEQ_WAIT && adc_result.valid;
        seq_done    = state_q == SEQ_PICK && idx_q == 3'(NUM_CH);
        needs_delay = idx_q <= CH_PRESS2 || first_q;
        delay_load  = 20'((32'(first_conversion_delay) + 1) * FCD_STEP_CYC);
    end

    // unsigned limit comparisons
    always_comb
    begin
        side_below  = adc_result.data < limits_q[1];
        side_above  = adc_result.data > limits_q[0];
        therm_below = adc_result.data < limits_q[3];
        therm_above = adc_result.data > limits_q[2];
    end

    // limit evaluation
    always_comb
    begin
        flags_d = ctrl_q[SIDE_LOW_BIT:THERM_HIGH_BIT];
        if (result_take)
        begin
            if (slot == CH_AUX)
            begin
                flags_d[3] = side_below;
                flags_d[2] = side_above;
            end
            else if (slot == CH_AUX + 3'h1)
            begin
                flags_d[1] = therm_below;
                flags_d[0] = therm_above;
            end
        end
    end

    // control register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ctrl_q <= SEQ_CTRL_RESET;
        else
        begin
            if (ctrl_wr)
            begin
                ctrl_q[15:12] <= reg_req.wdata[15:12];
                ctrl_q[7:0]   <= reg_req.wdata[7:0] & SEQ_CTRL_WR_MASK[7:0];
            end
            ctrl_q[SIDE_LOW_BIT:THERM_HIGH_BIT] <= flags_d;
        end
    end

    // limit registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            for (int k = 0; k < 4; k++)
                limits_q[k] <= LIMIT_RESET;
        end
        else if (reg_req.wr && limit_hit)
            limits_q[reg_req.addr[1:0]] <= reg_req.wdata;
    end

    // result registers, written only by the sequencer
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            for (int k = 0; k < NUM_RESULTS; k++)
                results_q[k] <= RESULT_RESET;
        end
        else if (result_take)
            results_q[slot] <= adc_result.data;
    end

    // register read port
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= reg_req.rd;
            if (reg_req.rd)
                rd_data_q <= rd_data_d;
        end
    end

    // read data select
    always_comb
    begin
        if (reg_req.addr == SEQ_CTRL_ADDR)
            rd_data_d = ctrl_q;
        else if (limit_hit)
            rd_data_d = limits_q[reg_req.addr[1:0]];
        else if (result_hit)
            rd_data_d = results_q[3'(reg_req.addr - RESULT_FIRST_ADDR)];
        else if (reg_req.addr == IDENTITY_ADDR)
            rd_data_d = IDENTITY_WORD;
        else
            rd_data_d = 16'h0000;
    end

    // sequencer
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_q        <= SEQ_IDLE;
            idx_q          <= 3'h0;
            delay_q        <= 20'h0;
            first_q        <= 1'b1;
            conv_start_q   <= 1'b0;
            conv_channel_q <= 3'h0;
            seq_busy_q     <= 1'b0;
        end
        else
        begin
            conv_start_q <= 1'b0;
            case (state_q)
                SEQ_IDLE:
                begin
                    if (seq_start)
                    begin
                        idx_q      <= 3'h0;
                        seq_busy_q <= 1'b1;
                        state_q    <= SEQ_PICK;
                    end
                end
                SEQ_PICK:
                begin
                    if (seq_done)
                    begin
                        seq_busy_q <= 1'b0;
                        state_q    <= SEQ_IDLE;
                    end
                    else if (chan_en[idx_q])
                    begin
                        conv_channel_q <= idx_q;
                        delay_q <= delay_load;
                        if (needs_delay)
                            state_q <= SEQ_DELAY;
                        else
                            state_q <= SEQ_CONV;
                    end
                    else
                        idx_q <= idx_q + 3'h1;
                end
                SEQ_DELAY:
                begin
                    if (delay_q <= 20'h1)
                        state_q <= SEQ_CONV;
                    else
                        delay_q <= delay_q - 20'h1;
                end
                SEQ_CONV:
                begin
                    conv_start_q <= 1'b1;
                    state_q      <= SEQ_WAIT;
                end
                SEQ_WAIT:
                begin
                    if (adc_result.valid)
                    begin
                        first_q <= 1'b0;
                        idx_q   <= idx_q + 3'h1;
                        state_q <= SEQ_PICK;
                    end
                end
                default:
                    state_q <= SEQ_IDLE;
            endcase
        end
    end

    // data-ready flag and latched pin event
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            result_ready_q <= 1'b0;
            gpio_seen_q    <= 1'b0;
        end
        else
        begin
            if (seq_done)
                result_ready_q <= 1'b1;
            else if (seq_start || (reg_req.rd && result_hit))
                result_ready_q <= 1'b0;
            // set wins over the clearing write
            if (gpio_sync_q[1])
                gpio_seen_q <= 1'b1;
            else if (ctrl_wr)
                gpio_seen_q <= 1'b0;
        end
    end

    // alert sources
    always_comb
    begin
        alert_req = 1'b0;
        if (!ctrl_q[THERM_MASK_BIT])
            alert_req = alert_req | ctrl_q[THERM_LOW_BIT] | ctrl_q[THERM_HIGH_BIT];
        if (!ctrl_q[SIDE_MASK_BIT])
            alert_req = alert_req | ctrl_q[SIDE_LOW_BIT] | ctrl_q[SIDE_HIGH_BIT];
        if (!ctrl_q[GPIO_MASK_BIT])
            alert_req = alert_req | gpio_seen_q;
        if (ctrl_q[ALERT_MODE_BIT])
            irq_level = alert_req;
        else
            irq_level = result_ready_q;
    end

    // shared active-low output
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            touch_detect_output_n_q <= 1'b1;
        else if (!pen_irq_enable)
            touch_detect_output_n_q <= ~touch_sync_q[1];
        else
            touch_detect_output_n_q <= ~irq_level;
    end

endmodule : touch_adc_sequence_alert_regs

// ---- touch_regs_pkg.sv ----
package touch_regs_pkg;

    // register offsets
    localparam logic [7:0] SEQ_CTRL_ADDR      = 8'h03;
    localparam logic [7:0] SIDE_HIGH_ADDR     = 8'h04;
    localparam logic [7:0] SIDE_LOW_ADDR      = 8'h05;
    localparam logic [7:0] THERM_HIGH_ADDR    = 8'h06;
    localparam logic [7:0] THERM_LOW_ADDR     = 8'h07;
    localparam logic [7:0] RESULT_FIRST_ADDR  = 8'h08;
    localparam logic [7:0] RESULT_LAST_ADDR   = 8'h0d;
    localparam logic [7:0] IDENTITY_ADDR      = 8'h0e;

    // sequence and alert control fields
    localparam int THERM_MASK_BIT   = 15;
    localparam int SIDE_MASK_BIT    = 14;
    localparam int ALERT_MODE_BIT   = 13;
    localparam int GPIO_MASK_BIT    = 12;
    localparam int SIDE_LOW_BIT     = 11;
    localparam int SIDE_HIGH_BIT    = 10;
    localparam int THERM_LOW_BIT    = 9;
    localparam int THERM_HIGH_BIT   = 8;
    localparam int SEQ_EN_TOP_BIT   = 7;

    // host-writable bits of the control register: 15..12 and 7..1
    localparam logic [15:0] SEQ_CTRL_WR_MASK = 16'hf0fe;
    localparam logic [15:0] SEQ_CTRL_RESET   = 16'h1000;
    localparam logic [15:0] LIMIT_RESET      = 16'h0000;
    localparam logic [15:0] RESULT_RESET     = 16'h0000;

    // arbitrary identity value, bits 15..12 unused
    localparam logic [15:0] IDENTITY_WORD    = 16'h0a51;

    // channel numbers in sequence order
    localparam logic [2:0] CH_Y_POS    = 3'h0;
    localparam logic [2:0] CH_X_POS    = 3'h1;
    localparam logic [2:0] CH_PRESS1   = 3'h2;
    localparam logic [2:0] CH_PRESS2   = 3'h3;
    localparam logic [2:0] CH_AUX      = 3'h4;
    localparam logic [2:0] CH_BATT     = 3'h5;
    localparam logic [2:0] CH_THERM    = 3'h6;
    localparam int         NUM_CH      = 7;
    localparam int         NUM_RESULTS = 6;

    // first conversion delay: (code + 1) steps of 128 us
    localparam int CLK_PERIOD_NS       = 40;
    localparam int FCD_STEP_NS         = 128000;
    localparam int FCD_STEP_CYCLES     = (FCD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } adc_result_t;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_PICK,
        SEQ_DELAY,
        SEQ_CONV,
        SEQ_WAIT
    } seq_state_t;

endpackage : touch_regs_pkg

// ---- touch_regs_properties.sv ----
`timescale 1ns/1ps
module touch_regs_properties
    import touch_regs_pkg::*;
#(
    parameter int FCD_STEP_CYC = FCD_STEP_CYCLES
)(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire reg_req_t    reg_req,
    input wire logic [15:0] rd_data_q,
    input wire logic        rd_valid_q,
    input wire logic        seq_start,
    input wire logic [3:0]  first_conversion_delay,
    input wire logic        gpio_enable,
    input wire logic        pen_irq_enable,
    input wire logic        touch_pin,
    input wire logic        gpio_event_pin,
    input wire logic        conv_start_q,
    input wire logic [2:0]  conv_channel_q,
    input wire adc_result_t adc_result,
    input wire logic        seq_busy_q,
    input wire logic        touch_detect_output_n_q
);
    logic [7:1] en_q;
    int         gap_q;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // channel enables as last written by the host
    always_ff @(posedge core_clk)
        if (!rst_n)
            en_q <= '0;
        else if (reg_req.wr && reg_req.addr == SEQ_CTRL_ADDR)
            en_q <= reg_req.wdata[7:1];

    // cycles since sequence start or last result
    always_ff @(posedge core_clk)
        if (!rst_n || adc_result.valid || (seq_start && !seq_busy_q))
            gap_q <= 0;
        else if (gap_q < 100000)
            gap_q <= gap_q + 1;

    AST_RD_VALID: assert property (rd_valid_q == $past(reg_req.rd))
        else $error("read answer not one cycle after request");
    AST_RD_ID: assert property (reg_req.rd && reg_req.addr == IDENTITY_ADDR |=>
        rd_data_q == IDENTITY_WORD) else $error("identity word wrong");
    AST_SEQ_EN: assert property (conv_start_q |-> en_q[3'd7 - conv_channel_q])
        else $error("disabled channel converted");
    AST_GPIO_SKIP: assert property (conv_start_q && gpio_enable |->
        conv_channel_q != CH_AUX && conv_channel_q != CH_BATT) else $error("side channel run");
    AST_BATT_WINS: assert property (conv_start_q && conv_channel_q == CH_AUX |->
        !en_q[2] && !gpio_enable) else $error("aux converted while battery enabled");
    AST_FCD: assert property (conv_start_q && conv_channel_q <= CH_PRESS2 |->
        gap_q >= (int'(first_conversion_delay) + 1) * FCD_STEP_CYC)
        else $error("first conversion delay too short");
    AST_PEN: assert property ((!pen_irq_enable && touch_pin)[*4] |=>
        !touch_detect_output_n_q) else $error("touch not shown on shared output");
    AST_BUSY: assert property (seq_start && !seq_busy_q |=> seq_busy_q)
        else $error("sequence start not taken");

    cover property (conv_start_q && conv_channel_q == CH_BATT);
    cover property (!touch_detect_output_n_q && pen_irq_enable);
    cover property (rd_valid_q && rd_data_q == IDENTITY_WORD);
endmodule : touch_regs_properties
